// ### core/i2ct_timing_core.sv
/*
 * Timing register bank and bit-level sequencer for the two-wire bus.
 * Assumes a simple synchronous register port and open-drain pad logic
 * outside that turns the output enables into wire levels.
 */
`timescale 1ns/10ps
`default_nettype none
module i2ct_timing_core (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_ack,
    output logic             reg_err,
    // Bit commands from the controller
    input  wire logic        cmd_valid,
    input  wire logic [1:0]  cmd_op,
    input  wire logic        cmd_bit,
    output logic             cmd_ready,
    output logic             cmd_done,
    output logic             rx_bit,
    output logic             bus_busy,
    // Bus pins
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);
    typedef enum logic [3:0] {
        S_IDLE   = 4'h0,
        S_FREE   = 4'h1,
        S_SHOLD  = 4'h2,
        S_LOW    = 4'h3,
        S_PARK   = 4'h4,
        S_DHOLD  = 4'h5,
        S_DSETUP = 4'h6,
        S_HIGH   = 4'h7,
        S_RHOLD  = 4'h8,
        S_RSETUP = 4'h9,
        S_PHOLD  = 4'ha,
        S_PSETUP = 4'hb
    } i2ct_state_t;

    i2ct_line_if lines ();

    i2ct_line_filter u_filter (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .lines   (lines)
    );

    logic [31:0]  cfg_q [i2ct_pkg::NREG];
    logic [7:0]   hit_w;
    logic [31:0]  rsel_w;
    i2ct_state_t  st_q, st_d;
    logic [31:0]  cnt_q;
    logic [31:0]  tgt_w;
    logic         timed_w, wait_hi_w, expire_w;
    logic         scl_oe_q, sda_oe_q, sda_oe_d, done_q, rx_q, bit_q;
    logic         scl_prev_q, sda_prev_q, busy_q;
    logic [31:0]  free_q;
    logic         start_det_w, stop_det_w, free_ok_w, take_w;
    logic [31:0]  rdata_q;
    logic         ack_q, err_q, ready_q;

    // Address decode and read selection.
    genvar k;
    generate
        for (k = 0; k < i2ct_pkg::NREG; k++) begin : g_reg
            assign hit_w[k] = (reg_addr == i2ct_pkg::REG_OFS[k]);
            // Each count is full width and read/write; reset by grade.
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    cfg_q[k] <= i2ct_pkg::RST_VAL[k];
                end else if (reg_wr && hit_w[k]) begin
                    cfg_q[k] <= reg_wdata;
                end
            end
        end
    endgenerate

    always_comb begin
        rsel_w = 32'h0000_0000;
        for (int i = 0; i < i2ct_pkg::NREG; i++) begin
            if (hit_w[i]) begin
                rsel_w = cfg_q[i];
            end
        end
    end

    // Register answers come one cycle after the request.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= reg_rd ? rsel_w : 32'h0000_0000;
            ack_q   <= reg_rd || reg_wr;
            err_q   <= (reg_rd || reg_wr) && (hit_w == 8'h00);
        end
    end

    // Bus monitor: START and STOP seen from any master.
    assign start_det_w = lines.scl_level && sda_prev_q && !lines.sda_level;
    assign stop_det_w  = lines.scl_level && !sda_prev_q && lines.sda_level;
    assign free_ok_w   = !busy_q && (free_q >= cfg_q[i2ct_pkg::IX_BUF]);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            busy_q     <= 1'b0;
            free_q     <= 32'h0000_0000;
        end else begin
            scl_prev_q <= lines.scl_level;
            sda_prev_q <= lines.sda_level;
            if (start_det_w) begin
                busy_q <= 1'b1;
            end else if (stop_det_w) begin
                busy_q <= 1'b0;
            end
            // Bus-free time restarts on every STOP, ours or another's.
            if (stop_det_w || !lines.scl_level || !lines.sda_level) begin
                free_q <= 32'h0000_0000;
            end else if (free_q != 32'hffff_ffff) begin
                free_q <= free_q + 32'h0000_0001;
            end
        end
    end

    // Phase length for the current state; high phases wait for the clock.
    always_comb begin
        case (st_q)
            S_SHOLD:  tgt_w = cfg_q[i2ct_pkg::IX_SHD];
            S_LOW:    tgt_w = cfg_q[i2ct_pkg::IX_LO];
            S_DHOLD,
            S_RHOLD,
            S_PHOLD:  tgt_w = cfg_q[i2ct_pkg::IX_DHD];
            S_DSETUP: tgt_w = cfg_q[i2ct_pkg::IX_DSU];
            S_HIGH:   tgt_w = cfg_q[i2ct_pkg::IX_HI];
            S_RSETUP: tgt_w = cfg_q[i2ct_pkg::IX_RSU];
            S_PSETUP: tgt_w = cfg_q[i2ct_pkg::IX_SSU];
            default:  tgt_w = 32'h0000_0001;
        endcase
    end

    assign wait_hi_w = (st_q == S_HIGH) || (st_q == S_RSETUP)
                    || (st_q == S_PSETUP);
    assign timed_w   = wait_hi_w ? lines.scl_level : 1'b1;
    // A count of zero acts as one cycle.
    assign expire_w  = timed_w
                    && ({1'b0, cnt_q} + 33'h1 >= {1'b0, tgt_w});
    assign take_w    = cmd_valid
                    && (((st_q == S_IDLE) && (cmd_op == i2ct_pkg::CMD_START))
                    || ((st_q == S_PARK) && (cmd_op != i2ct_pkg::CMD_START)));

    // Sequencer next state.
    always_comb begin
        st_d = st_q;
        case (st_q)
            S_IDLE:   if (take_w) st_d = S_FREE;
            S_FREE:   if (free_ok_w) st_d = S_SHOLD;
            S_SHOLD:  if (expire_w) st_d = S_LOW;
            S_LOW:    if (expire_w) st_d = S_PARK;
            S_PARK: begin
                if (take_w) begin
                    case (cmd_op)
                        i2ct_pkg::CMD_BIT:    st_d = S_DHOLD;
                        i2ct_pkg::CMD_RSTART: st_d = S_RHOLD;
                        default:              st_d = S_PHOLD;
                    endcase
                end
            end
            S_DHOLD:  if (expire_w) st_d = S_DSETUP;
            S_DSETUP: if (expire_w) st_d = S_HIGH;
            S_HIGH:   if (expire_w) st_d = S_LOW;
            S_RHOLD:  if (expire_w) st_d = S_RSETUP;
            S_RSETUP: if (expire_w) st_d = S_SHOLD;
            S_PHOLD:  if (expire_w) st_d = S_PSETUP;
            S_PSETUP: if (expire_w) st_d = S_IDLE;
            default:  st_d = S_IDLE;
        endcase
    end

    // Data line drive for the phase being entered.
    always_comb begin
        case (st_d)
            S_SHOLD, S_PHOLD, S_PSETUP: sda_oe_d = 1'b1;
            S_RHOLD, S_RSETUP, S_IDLE,
            S_FREE:                     sda_oe_d = 1'b0;
            S_DSETUP, S_HIGH:           sda_oe_d = !bit_q;
            S_LOW:    sda_oe_d = (st_q == S_HIGH) ? sda_oe_q : 1'b1;
            default:                    sda_oe_d = sda_oe_q;
        endcase
    end

    // Sequencer registers; counts restart at every phase entry.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q     <= S_IDLE;
            cnt_q    <= 32'h0000_0000;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            done_q   <= 1'b0;
            rx_q     <= 1'b0;
            bit_q    <= 1'b1;
            ready_q  <= 1'b1;
        end else begin
            st_q     <= st_d;
            cnt_q    <= (st_d != st_q || !timed_w) ? 32'h0000_0000
                                                   : cnt_q + 32'h0000_0001;
            scl_oe_q <= (st_d == S_LOW) || (st_d == S_PARK)
                     || (st_d == S_DHOLD) || (st_d == S_DSETUP)
                     || (st_d == S_RHOLD) || (st_d == S_PHOLD);
            sda_oe_q <= sda_oe_d;
            // Ready is registered from the next state so it tracks st_q.
            ready_q  <= (st_d == S_IDLE) || (st_d == S_PARK);
            done_q   <= ((st_q == S_LOW) || (st_q == S_PSETUP)) && expire_w;
            if (take_w) begin
                bit_q <= cmd_bit;
            end
            if ((st_q == S_HIGH) && expire_w) begin
                rx_q <= lines.sda_level;
            end
        end
    end

    // Outputs, all from flip-flops except scl_o and sda_o, which are tied low.
    assign reg_rdata = rdata_q;
    assign reg_ack   = ack_q;
    assign reg_err   = err_q;
    assign cmd_done  = done_q;
    assign rx_bit    = rx_q;
    assign bus_busy  = busy_q;
    assign cmd_ready = ready_q;
    assign scl_oe    = scl_oe_q;
    assign sda_oe    = sda_oe_q;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
endmodule // i2ct_timing_core
`default_nettype wire

// ### common/i2ct_pkg.sv
/*
 * Constants of the two-wire bus timing bank: register offsets, speed-grade
 * time tables, reset values of the eight counts and sequencer encodings.
 * Assumes a 20 MHz core clock and one speed grade chosen at build time.
 */
//Contract
//- Hold a 32-bit read/write repeated-START setup count in core cycles.
//- Hold a 32-bit read/write STOP setup count in core cycles.
//- Hold a 32-bit start hold count before the clock first falls.
//- Hold a 32-bit data setup count before the clock rises.
//- Hold a 32-bit bus-free count enforced between STOP and next START.
//- Apply bus-free time after any observed STOP, from any master.
//- Hold a 32-bit read/write clock high period count.
//- Default high count is fclk/(2*fbus) minus 7 minus clock filter depth.
//- Hold a 32-bit clock low period count, default derived like high.
//- Hold a 32-bit data hold count after the clock falls.
//- All counts reset to defaults from clock rate and speed grade.
//- Optionally filter incoming clock and data lines; depth zero disables.
package i2ct_pkg;

    // Core clock rate.
    localparam int unsigned CLK_HZ = 20000000;

    // Speed grades.
    typedef enum logic [1:0] {
        I2CT_STD  = 2'b00,
        I2CT_FAST = 2'b01,
        I2CT_FMP  = 2'b10
    } i2ct_grade_t;
    localparam i2ct_grade_t GRADE = I2CT_STD;

    // Glitch filter depth on incoming lines, in core cycles.
    localparam int unsigned SCL_FILT_DEPTH = 2;
    localparam int unsigned SDA_FILT_DEPTH = 2;
    localparam int unsigned FILT_W         = 4;

    // Register byte offsets, in index order of the bank.
    localparam int unsigned NREG = 8;
    localparam logic [11:0] OFS_RESTART_SETUP = 12'h128;
    localparam logic [11:0] OFS_STOP_SETUP    = 12'h12c;
    localparam logic [11:0] OFS_START_HOLD    = 12'h130;
    localparam logic [11:0] OFS_DATA_SETUP    = 12'h134;
    localparam logic [11:0] OFS_BUS_FREE      = 12'h138;
    localparam logic [11:0] OFS_CLOCK_HIGH    = 12'h13c;
    localparam logic [11:0] OFS_CLOCK_LOW     = 12'h140;
    localparam logic [11:0] OFS_DATA_HOLD     = 12'h144;
    localparam logic [11:0] REG_OFS [NREG] = '{OFS_RESTART_SETUP,
        OFS_STOP_SETUP, OFS_START_HOLD, OFS_DATA_SETUP, OFS_BUS_FREE,
        OFS_CLOCK_HIGH, OFS_CLOCK_LOW, OFS_DATA_HOLD};
    localparam int unsigned IX_RSU = 0;
    localparam int unsigned IX_SSU = 1;
    localparam int unsigned IX_SHD = 2;
    localparam int unsigned IX_DSU = 3;
    localparam int unsigned IX_BUF = 4;
    localparam int unsigned IX_HI  = 5;
    localparam int unsigned IX_LO  = 6;
    localparam int unsigned IX_DHD = 7;

    // Bus rates and times in ns per grade: standard, fast, fast plus.
    localparam int unsigned BUS_HZ [3]    = '{100000, 400000, 1000000};
    localparam int unsigned T_SU_STA [3]  = '{4700, 600, 260};
    localparam int unsigned T_RISE [3]    = '{1000, 300, 120};
    localparam int unsigned T_SU_STO [3]  = '{4000, 600, 260};
    localparam int unsigned T_HD_STA [3]  = '{4000, 600, 260};
    localparam int unsigned T_SU_DAT [3]  = '{250, 100, 50};
    localparam int unsigned T_BUF [3]     = '{4700, 1300, 500};
    localparam int unsigned T_HD_DAT [3]  = '{300, 300, 0};
    localparam int unsigned HALF_OFFSET   = 7;

    // Least time in ns to whole core cycles, rounded up, at least one.
    function automatic logic [31:0] ns_to_cyc(input int unsigned ns);
        longint unsigned c;
        c = (longint'(ns) * CLK_HZ + 64'd999999999) / 64'd1000000000;
        return (c == 0) ? 32'h0000_0001 : c[31:0];
    endfunction

    // Half bus period less the fixed offset and the clock filter depth.
    localparam int unsigned G = int'(GRADE);
    localparam logic [31:0] HALF_CYC = 32'(CLK_HZ / (2 * BUS_HZ[G])
        - HALF_OFFSET - SCL_FILT_DEPTH);

    // Reset values of the bank, in index order.
    localparam logic [31:0] RST_VAL [NREG] = '{
        ns_to_cyc(T_SU_STA[G] + T_RISE[G]), ns_to_cyc(T_SU_STO[G]),
        ns_to_cyc(T_HD_STA[G]), ns_to_cyc(T_SU_DAT[G]),
        ns_to_cyc(T_BUF[G]), HALF_CYC, HALF_CYC, ns_to_cyc(T_HD_DAT[G])};

    // Sequencer commands.
    typedef enum logic [1:0] {
        CMD_START  = 2'b00,
        CMD_BIT    = 2'b01,
        CMD_RSTART = 2'b10,
        CMD_STOP   = 2'b11
    } i2ct_cmd_t;

endpackage

// ### common/i2ct_line_if.sv
/*
 * Filtered bus line levels passed from the input filter to the core.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none
interface i2ct_line_if;
    logic scl_level;
    logic sda_level;
    modport filt (output scl_level, output sda_level);
    modport core (input scl_level, input sda_level);
endinterface
`default_nettype wire

// ### core/i2ct_line_filter.sv
/*
 * Synchroniser and glitch filter for the incoming clock and data lines.
 * Assumes raw pin levels from outside the ref_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module i2ct_line_filter (
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rstn,
    // Raw pins
    input  wire logic  scl_i,
    input  wire logic  sda_i,
    // Filtered levels
    i2ct_line_if.filt  lines
);
    localparam logic [i2ct_pkg::FILT_W-1:0] DEPTH [2] = '{
        i2ct_pkg::FILT_W'(i2ct_pkg::SCL_FILT_DEPTH),
        i2ct_pkg::FILT_W'(i2ct_pkg::SDA_FILT_DEPTH)};

    logic [1:0] raw_w;
    logic [1:0] lvl_w;
    assign raw_w = {sda_i, scl_i};
    assign lines.scl_level = lvl_w[0];
    assign lines.sda_level = lvl_w[1];

    genvar k;
    generate
        for (k = 0; k < 2; k++) begin : g_line
            logic [2:0]                  sync_q;
            logic [i2ct_pkg::FILT_W-1:0] cnt_q;
            logic                        lvl_q;
            logic                        agree_w;
            logic                        diff_w;
            assign agree_w = (sync_q[1] == sync_q[2]);
            assign diff_w  = agree_w && (sync_q[2] != lvl_q);
            assign lvl_w[k] = lvl_q;
            // Lines idle high; a change takes effect after DEPTH+1 cycles with the last two synchroniser stages agreeing.
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    sync_q <= 3'h7;
                    cnt_q  <= '0;
                    lvl_q  <= 1'b1;
                end else begin
                    sync_q <= {sync_q[1:0], raw_w[k]};
                    if (!diff_w) begin
                        cnt_q <= '0;
                    end else if (cnt_q >= DEPTH[k]) begin
                        lvl_q <= sync_q[2];
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + i2ct_pkg::FILT_W'(1);
                    end
                end
            end
        end
    endgenerate
endmodule // i2ct_line_filter
`default_nettype wire

// ### tb/i2ct_timing_asserts.sv
/*
 * Checker of the timing bank and sequencer on the core's ports.
 * Assumes one clock domain and the offsets of the package.
 */
`timescale 1ns/10ps
`default_nettype none
module i2ct_timing_asserts (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        reg_err,
    // Sequencer and pins
    input wire logic        cmd_done,
    input wire logic        cmd_ready,
    input wire logic        bus_busy,
    input wire logic        scl_oe,
    input wire logic        sda_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Decode of places outside the bank and of start hold writes.
    wire logic unmapped = (reg_addr < i2ct_pkg::OFS_RESTART_SETUP)
        || (reg_addr > i2ct_pkg::OFS_DATA_HOLD) || (reg_addr[1:0] != 2'h0);
    wire logic hold_wr = reg_wr && (reg_addr == i2ct_pkg::OFS_START_HOLD);
    logic [31:0] hold_cfg_q;
    logic [31:0] hold_cnt_q;
    logic        hold_arm_q;
    wire logic [31:0] hold_exp = (hold_cfg_q == 32'h0) ? 32'h1 : hold_cfg_q;

    // Shadows the hold count and times sda pulled with scl released.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hold_cfg_q <= i2ct_pkg::RST_VAL[i2ct_pkg::IX_SHD];
            hold_cnt_q <= 32'h0;
            hold_arm_q <= 1'b0;
        end else begin
            if (hold_wr) hold_cfg_q <= reg_wdata;
            hold_cnt_q <= $rose(sda_oe) ? 32'h1 : hold_cnt_q + 32'h1;
            if ($rose(sda_oe) && !scl_oe) hold_arm_q <= 1'b1;
            else if ($rose(scl_oe)) hold_arm_q <= 1'b0;
        end
    end

    // A write of the restart count followed by a read of it.
    sequence s_rsu_wr;
        reg_wr && (reg_addr == i2ct_pkg::OFS_RESTART_SETUP);
    endsequence
    sequence s_rsu_rd;
        reg_rd && (reg_addr == i2ct_pkg::OFS_RESTART_SETUP);
    endsequence
    property p_ack_follows; (reg_wr || reg_rd) |=> reg_ack; endproperty
    property p_err_decode;
        (reg_wr || reg_rd) |=> (reg_err == $past(unmapped));
    endproperty
    property p_rdata_idle; !reg_ack |-> (reg_rdata == 32'h0); endproperty
    property p_readback;
        s_rsu_wr ##1 s_rsu_rd |=> (reg_rdata == $past(reg_wdata, 2));
    endproperty
    property p_done_pulse; cmd_done |=> !cmd_done; endproperty
    property p_idle_quiet;
        cmd_ready && !bus_busy |-> !scl_oe && !sda_oe;
    endproperty
    property p_start_hold;
        $rose(scl_oe) && hold_arm_q |-> (hold_cnt_q == hold_exp);
    endproperty
    property p_stop_done; $fell(sda_oe) && !scl_oe |-> ##[0:2] cmd_done;
    endproperty

    a_ack_follows : assert property (p_ack_follows)
        else $error("access without acknowledge");
    a_err_decode : assert property (p_err_decode)
        else $error("error flag does not match the address");
    a_rdata_idle : assert property (p_rdata_idle)
        else $error("read data outside the acknowledge cycle");
    a_readback : assert property (p_readback)
        else $error("restart setup count not read back");
    a_done_pulse : assert property (p_done_pulse)
        else $error("done longer than one cycle");
    a_idle_quiet : assert property (p_idle_quiet)
        else $error("line pulled while idle and free");
    a_start_hold : assert property (p_start_hold)
        else $error("start hold length wrong");
    a_stop_done : assert property (p_stop_done)
        else $error("stop without done");
endmodule // i2ct_timing_asserts
bind i2ct_timing_core i2ct_timing_asserts u_asserts (.ref_clk, .rstn,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .reg_err,
    .cmd_done, .cmd_ready, .bus_busy, .scl_oe, .sda_oe);
`default_nettype wire

// ### tb/i2ct_bus_slave.sv
/*
 * Slave that stretches the clock, plus a second master on sda.
 * Assumes pull-ups: a line that no party pulls reads high.
 */
`timescale 1ns/10ps
`default_nettype none
module i2ct_bus_slave (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Device pin enables
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    // Behaviour chosen by the bench
    input  wire logic [7:0] stretch_cyc,
    input  wire logic       slave_sda_low,
    input  wire logic       ext_sda_low,
    // Wire levels
    output logic            scl_i,
    output logic            sda_i
);
    logic       oe_d1_q;
    logic [7:0] hold_q;
    wire logic  rel = oe_d1_q && !scl_oe && (stretch_cyc != 8'h0);

    // Keeps scl low for stretch_cyc cycles after each release.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            oe_d1_q <= 1'b0;
            hold_q  <= 8'h0;
        end else begin
            oe_d1_q <= scl_oe;
            hold_q  <= rel ? stretch_cyc - 8'h1
                     : hold_q - {7'h0, hold_q != 8'h0};
        end
    end

    // Wired-AND of every party over the pull-ups.
    assign scl_i = !(scl_oe || rel || (hold_q != 8'h0));
    assign sda_i = !(sda_oe || slave_sda_low || ext_sda_low);
endmodule // i2ct_bus_slave
`default_nettype wire

// ### tb/i2c_bus_timing_parameters_tb_top.sv
/*
 * Bench of the timing bank: defaults, access, phase lengths, stretching
 * and a second master. Assumes the bus model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_timing_parameters_tb_top;
    localparam int NS_TAB [8] = '{4700 + 1000, 4000, 4000, 250, 4700, 0, 0,
        300};
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] reg_addr = 12'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic        reg_ack, reg_err, cmd_ready, cmd_done, rx_bit, bus_busy;
    logic        cmd_valid = 1'b0;
    logic [1:0]  cmd_op = 2'h0;
    logic        cmd_bit = 1'b0;
    logic        scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
    logic [7:0]  stretch_cyc = 8'h0;
    logic        slave_low = 1'b0;
    logic        ext_low = 1'b0;
    int          miscompares = 0;
    int          tests_run = 0;
    int          seed = 70953;
    int          model [8];
    int          dflt [8];
    int          uses [8] = '{1, 1, 2, 1, 1, 1, 3, 3};

    // Clock of 50 ns.
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    i2ct_timing_core dut (.ref_clk, .rstn, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .cmd_valid, .cmd_op,
        .cmd_bit, .cmd_ready, .cmd_done, .rx_bit, .bus_busy, .scl_i, .scl_o,
        .scl_oe, .sda_i, .sda_o, .sda_oe);
    i2ct_bus_slave u_bus (.ref_clk, .rstn, .scl_oe, .sda_oe, .stretch_cyc,
        .slave_sda_low(slave_low), .ext_sda_low(ext_low), .scl_i, .sda_i);

    // Compares one value and counts it.
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One register access; the request stays up until the next call.
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        chk("ack", 32'h1, {31'h0, reg_ack});
        q = reg_rdata;
        e = reg_err;
    endtask

    // Writes a count and keeps the model in step.
    task automatic put(input int k, input int v);
        logic [31:0] q;
        logic e;
        model[k] = v;
        bus(1'b1, i2ct_pkg::REG_OFS[k], v, q, e);
        reg_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    // Issues a command and counts cycles until done.
    task automatic do_cmd(input logic [1:0] op, input logic b,
                          output int dur);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_bit = b;
        dur = 0;
        do begin
            @(negedge ref_clk);
            dur++;
        end while (cmd_ready !== 1'b0 && dur < 9000);
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && dur < 9000) begin
            @(negedge ref_clk);
            dur++;
        end
        if (dur >= 9000) begin
            miscompares++;
            conclude();
        end
    endtask

    // START, one bit, repeated START and STOP; returns the summed length.
    task automatic trial(output int tot);
        int d;
        logic b;
        logic low;
        b = 1'($random(seed));
        low = 1'($random(seed));
        do_cmd(i2ct_pkg::CMD_START, 1'b0, tot);
        slave_low = low;
        do_cmd(i2ct_pkg::CMD_BIT, b, d);
        slave_low = 1'b0;
        chk("rx_bit", {31'h0, b && !low}, {31'h0, rx_bit});
        tot += d;
        do_cmd(i2ct_pkg::CMD_RSTART, 1'b1, d);
        tot += d;
        do_cmd(i2ct_pkg::CMD_STOP, 1'b0, d);
        tot += d;
    endtask

    // Main sequence.
    initial begin
        logic [31:0] q;
        logic e;
        int base;
        int t;
        int dl;
        for (int k = 0; k < 8; k++) dflt[k] = (NS_TAB[k] + 49) / 50;
        dflt[5] = 20000000 / (2 * 100000) - 7 - i2ct_pkg::SCL_FILT_DEPTH;
        dflt[6] = dflt[5];
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        @(negedge ref_clk);
        for (int k = 0; k < 8; k++) begin
            model[k] = dflt[k];
            bus(1'b0, i2ct_pkg::REG_OFS[k], 32'h0, q, e);
            chk("default", model[k], q);
        end
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, k ? 12'h148 : 12'h124, 32'h5, q, e);
            bus(1'b0, k ? 12'h148 : 12'h124, 32'h0, q, e);
            chk("unmapped", 32'h1, {31'h0, e && q == 32'h0});
        end
        $display("defaults test done");
        for (int k = 0; k < 8; k++) begin
            dl = $random(seed);
            model[k] = dl;
            bus(1'b1, i2ct_pkg::REG_OFS[k], dl, q, e);
            bus(1'b0, i2ct_pkg::REG_OFS[k], 32'h0, q, e);
            chk("readback", model[k], q);
        end
        for (int k = 0; k < 8; k++) put(k, dflt[k]);
        $display("access test done");
        trial(t);
        for (int k = 0; k < 8; k++) begin
            dl = ($random(seed) & 7) + 1;
            put(k, dflt[k]);
            trial(base);
            put(k, dflt[k] + dl);
            trial(t);
            chk("phase sum", base + dl * uses[k], t);
        end
        put(7, dflt[7]);
        trial(base);
        dl = ($random(seed) & 15) + 1;
        stretch_cyc = dl[7:0];
        put(7, dflt[7]);
        trial(t);
        chk("stretched sum", base + 3 * dl, t);
        stretch_cyc = 8'h0;
        $display("phase test done");
        repeat (200) @(negedge ref_clk);
        ext_low = 1'b1;
        repeat (12) @(negedge ref_clk);
        chk("busy", 32'h1, {31'h0, bus_busy});
        chk("pin drive", 32'h0, {30'h0, scl_o, sda_o});
        ext_low = 1'b0;
        do_cmd(i2ct_pkg::CMD_START, 1'b0, t);
        chk("free wait", 32'h1, {31'h0, t > model[4]});
        do_cmd(i2ct_pkg::CMD_STOP, 1'b0, t);
        $display("second master test done");
        conclude();
    end
endmodule // i2c_bus_timing_parameters_tb_top
`default_nettype wire
